// ==== hdl/cks_pkg.sv ====
// constants, field layout and state types for the system clock select block
// assumes a 32-bit apb register bus and a 10 MHz block clock
package cks_pkg;

  // ***********************************************
  // register map
  // ***********************************************
  localparam int           ADDR_W      = 8;
  localparam logic [7:0]   ADDR_CTRL   = 8'h00;
  localparam logic [7:0]   ADDR_STAT   = 8'h04;
  localparam logic [7:0]   ADDR_CFG    = 8'h08;
  localparam int           IFS_LSB     = 3;
  localparam int           IFS_MSB     = 6;
  localparam int           SEL_LSB     = 0;
  localparam int           SEL_MSB     = 1;
  localparam int           ST_SEC_RDY  = 7;
  localparam int           ST_TIMEOUT  = 5;
  localparam int           ST_HF_RDY   = 4;
  localparam int           ST_LF_RDY   = 1;
  localparam int           ST_HF_STB   = 0;
  localparam int           CFG_SEC_EN  = 0;

  // ***********************************************
  // reset values and encodings
  // ***********************************************
  localparam logic [3:0]   IFS_RESET   = 4'h7;
  localparam logic [1:0]   SEL_RESET   = 2'h0;
  localparam logic [1:0]   SEL_FUSED   = 2'h0;
  localparam logic [1:0]   SEL_SEC     = 2'h1;
  localparam logic [3:0]   IFS_FIRST_HF = 4'h2;
  localparam logic [3:0]   IFS_TOP     = 4'hF;
  localparam logic [3:0]   IFS_MID_TOP = 4'hC;
  localparam logic [3:0]   SHIFT_MAX   = 4'h9;
  localparam logic [2:0]   FOSC_LOW_GAIN  = 3'h0;
  localparam logic [2:0]   FOSC_MID_GAIN  = 3'h1;
  localparam logic [2:0]   FOSC_HIGH_GAIN = 3'h2;
  localparam logic [2:0]   FOSC_INTERNAL  = 3'h4;

  // ***********************************************
  // timing
  // ***********************************************
  localparam int           OST_COUNT_DEF = 1024;
  localparam int           OST_W       = 11;
  localparam int           HF_CNT_W    = 9;

  // sync vector lanes
  localparam int           SY_EXT      = 0;
  localparam int           SY_SEC      = 1;
  localparam int           SY_LF       = 2;
  localparam int           SY_HF       = 3;
  localparam int           SY_N        = 4;

  typedef enum logic [1:0] {SRC_FUSED, SRC_SEC, SRC_INT} cks_src_t;
  typedef enum logic [1:0] {SW_IDLE, SW_START, SW_FALL, SW_HOLD} cks_sw_t;

endpackage : cks_pkg

// ==== hdl/cks_clock_select.sv ====
// system clock source selection, glitch-free switching and two-speed start-up
// assumes oscillator waveforms arrive as levels synchronous to clk, slower than clk/2
//
// Behaviour
// - reset loads frequency select 0111, 500 kHz
// - select 00 uses fused oscillator mode source
// - select 01 uses secondary crystal oscillator
// - select 1x uses internal block frequency
// - reset clears system clock select
// - automatic switches leave select field unchanged
// - frequency switch: start, fall, hold, rise
// - same-oscillator frequency change skips start-up wait
// - hf oscillator enable on hf code
// - hf ready flag while hf usable
// - hf stable flag within half percent
// - lf oscillator enable on lf or timers
// - lf ready flag while lf usable
// - postscaler offers listed hf and lf rates
// - timeout flag shows fused external source
// - secondary oscillator runs only when enabled
// - internal mode frees pins, clock-out fuse
// - two-speed only in crystal modes
// - run internal while timer counts 1024
// - sleep aborts start-up, flag stays clear
// - frequency select code decode table
// - two-speed needs fuse, select 00, entry
// - end: internal fall, flag, crystal fall
`timescale 1ns/1ns
module cks_clock_select #(
  parameter int OST_COUNT = cks_pkg::OST_COUNT_DEF
) (
  input  wire logic                      clk,                // 10 MHz block clock
  input  wire logic                      rst,                // async reset, active high
  input  wire logic                      psel,               // apb select
  input  wire logic                      penable,            // apb access phase
  input  wire logic                      pwrite,             // apb direction
  input  wire logic [cks_pkg::ADDR_W-1:0] paddr,             // apb byte address
  input  wire logic [31:0]               pwdata,             // apb write data
  output logic      [31:0]               prdata,             // apb read data
  output logic                           pready,             // apb ready
  output logic                           pslverr,            // apb error, unmapped address
  input  wire logic [2:0]                fused_osc_mode,     // fused oscillator mode
  input  wire logic                      two_speed_enable_fuse, // two-speed start-up fuse
  input  wire logic                      clk_out_enable_fuse_n, // low: clock-out on pin
  input  wire logic                      power_up_timer_done, // power-up timer expired
  input  wire logic                      power_up_timer_on,  // power-up timer needs lf
  input  wire logic                      watchdog_timer_on,  // watchdog needs lf
  input  wire logic                      failsafe_monitor_on, // fail-safe monitor needs lf
  input  wire logic                      sleep_req,          // device in sleep
  input  wire logic                      ext_osc_clk,        // fused external source
  input  wire logic                      sec_osc_clk,        // secondary crystal
  input  wire logic                      sec_osc_ready,      // secondary crystal usable
  input  wire logic                      lf_osc_clk,         // lf internal oscillator
  input  wire logic                      lf_osc_ready,       // lf running
  input  wire logic                      hf_osc_clk,         // hf internal oscillator
  input  wire logic                      hf_osc_ready,       // hf running
  input  wire logic                      hf_osc_stable,      // hf within tolerance
  output logic                           hf_osc_en,          // hf oscillator enable
  output logic                           lf_osc_en,          // lf oscillator enable
  output logic                           sec_osc_en,         // secondary oscillator enable
  output logic                           sys_clk_out,        // glitch-free system clock
  output logic [1:0]                     sys_clk_src,        // source now driving the clock
  output logic                           primary_pin_gpio,   // primary input pin is i/o
  output logic                           secondary_pin_clkout // secondary pin drives clock-out
);

  // ***********************************************
  // state
  // ***********************************************
  typedef struct packed {
    logic [3:0]                   ifs;
    logic [1:0]                   sel;
    logic                         sec_en;
    logic [cks_pkg::SY_N-1:0]     sy1;
    logic [cks_pkg::SY_N-1:0]     sy2;
    logic [cks_pkg::SY_N-1:0]     sy3;
    logic [cks_pkg::HF_CNT_W-1:0] hf_cnt;
    logic [cks_pkg::OST_W-1:0]    ost_cnt;
    logic                         ost_done;
    logic                         timeout;
    cks_pkg::cks_src_t            cur_src;
    logic [3:0]                   cur_ifs;
    cks_pkg::cks_src_t            new_src;
    logic [3:0]                   new_ifs;
    cks_pkg::cks_sw_t             sw;
    logic                         cur_d;
    logic                         new_d;
    logic                         clk_o;
    logic                         hf_en;
    logic                         lf_en;
    logic                         hf_rdy;
    logic                         hf_stb;
    logic                         lf_rdy;
    logic                         sec_rdy;
    logic [31:0]                  rdata;
  } cks_state_t;

  cks_state_t s_r;
  cks_state_t s_nxt;

  localparam logic [cks_pkg::OST_W-1:0] OST_LAST = cks_pkg::OST_W'(OST_COUNT - 1);

  // ***********************************************
  // decode helpers
  // ***********************************************
  function automatic logic is_lf(input logic [3:0] c);
    return c < cks_pkg::IFS_FIRST_HF;
  endfunction : is_lf

  // hf divide exponent: 16 MHz >> shift
  function automatic logic [3:0] ifs_shift(input logic [3:0] c);
    if (c[3])
      return cks_pkg::IFS_TOP - c;
    else if (c[2])
      return cks_pkg::IFS_MID_TOP - c;
    else
      return cks_pkg::SHIFT_MAX;
  endfunction : ifs_shift

  function automatic logic int_lvl(input logic [3:0] c, input logic [cks_pkg::HF_CNT_W-1:0] cnt,
                                   input logic hf, input logic lf);
    logic [3:0] sh;
    sh = ifs_shift(c);
    if (is_lf(c))
      return lf;
    else if (sh == 4'h0)
      return hf;
    else
      return cnt[sh - 4'h1];
  endfunction : int_lvl

  function automatic logic src_lvl(input cks_pkg::cks_src_t src, input logic [3:0] c,
                                   input logic [cks_pkg::HF_CNT_W-1:0] cnt,
                                   input logic [cks_pkg::SY_N-1:0] lv);
    unique case (src)
      cks_pkg::SRC_FUSED: return lv[cks_pkg::SY_EXT];
      cks_pkg::SRC_SEC:   return lv[cks_pkg::SY_SEC];
      default:            return int_lvl(c, cnt, lv[cks_pkg::SY_HF], lv[cks_pkg::SY_LF]);
    endcase
  endfunction : src_lvl

  function automatic logic is_xtal(input logic [2:0] m);
    return m == cks_pkg::FOSC_LOW_GAIN || m == cks_pkg::FOSC_MID_GAIN || m == cks_pkg::FOSC_HIGH_GAIN;
  endfunction : is_xtal

  // ***********************************************
  // combinational next state
  // ***********************************************
  logic              apb_acc;
  logic              apb_wr;
  logic              mapped;
  logic              fused_int;
  logic              xtal;
  logic              two_speed;
  logic              ext_rise;
  logic              hf_rise;
  cks_pkg::cks_src_t tgt_src;
  logic              tgt_ready;
  logic              cur_lvl;
  logic              new_lvl;
  logic              int_live;
  logic              int_next;
  logic              hf_busy;
  logic              lf_busy;

  always_comb begin
    s_nxt     = s_r;
    apb_acc   = psel && penable;
    apb_wr    = apb_acc && pwrite;
    mapped    = paddr == cks_pkg::ADDR_CTRL || paddr == cks_pkg::ADDR_STAT || paddr == cks_pkg::ADDR_CFG;
    fused_int = fused_osc_mode == cks_pkg::FOSC_INTERNAL;
    xtal      = is_xtal(fused_osc_mode);
    ext_rise  = s_r.sy2[cks_pkg::SY_EXT] && !s_r.sy3[cks_pkg::SY_EXT];
    hf_rise   = s_r.sy2[cks_pkg::SY_HF] && !s_r.sy3[cks_pkg::SY_HF];

    // source levels pass two flops before anything looks at them
    s_nxt.sy1 = {hf_osc_clk, lf_osc_clk, sec_osc_clk, ext_osc_clk};
    s_nxt.sy2 = s_r.sy1;
    s_nxt.sy3 = s_r.sy2;
    if (hf_rise)
      s_nxt.hf_cnt = s_r.hf_cnt + cks_pkg::HF_CNT_W'(1);

    // register writes; status is read-only
    if (apb_wr && paddr == cks_pkg::ADDR_CTRL) begin
      s_nxt.ifs = pwdata[cks_pkg::IFS_MSB:cks_pkg::IFS_LSB];
      s_nxt.sel = pwdata[cks_pkg::SEL_MSB:cks_pkg::SEL_LSB];
    end
    if (apb_wr && paddr == cks_pkg::ADDR_CFG)
      s_nxt.sec_en = pwdata[cks_pkg::CFG_SEC_EN];

    // start-up timer counts external edges; sleep aborts it
    two_speed = two_speed_enable_fuse && s_r.sel == cks_pkg::SEL_FUSED && xtal;
    if (sleep_req || !xtal) begin
      s_nxt.ost_cnt  = '0;
      s_nxt.ost_done = 1'b0;
    end else if (power_up_timer_done && !s_r.ost_done && ext_rise) begin
      s_nxt.ost_cnt = s_r.ost_cnt + cks_pkg::OST_W'(1);
      if (s_r.ost_cnt == OST_LAST)
        s_nxt.ost_done = 1'b1;
    end

    // wanted source; automatic choices never touch sel
    if (s_r.sel[1])
      tgt_src = cks_pkg::SRC_INT;
    else if (s_r.sel == cks_pkg::SEL_SEC)
      tgt_src = cks_pkg::SRC_SEC;
    else if (fused_int || (two_speed && !s_r.ost_done))
      tgt_src = cks_pkg::SRC_INT;
    else
      tgt_src = cks_pkg::SRC_FUSED;

    unique case (s_r.new_src)
      cks_pkg::SRC_FUSED: tgt_ready = !xtal || s_r.ost_done;
      cks_pkg::SRC_SEC:   tgt_ready = sec_osc_ready && s_r.sec_en;
      default:            tgt_ready = is_lf(s_r.new_ifs) ? lf_osc_ready : hf_osc_ready;
    endcase

    cur_lvl = src_lvl(s_r.cur_src, s_r.cur_ifs, s_r.hf_cnt, s_r.sy2);
    new_lvl = src_lvl(s_r.new_src, s_r.new_ifs, s_r.hf_cnt, s_r.sy2);
    s_nxt.cur_d = cur_lvl;
    s_nxt.new_d = new_lvl;

    // ***********************************************
    // switch sequencer
    // ***********************************************
    unique case (s_r.sw)
      cks_pkg::SW_IDLE: begin
        if (tgt_src != s_r.cur_src || (tgt_src == cks_pkg::SRC_INT && s_r.ifs != s_r.cur_ifs)) begin
          s_nxt.new_src = tgt_src;
          s_nxt.new_ifs = s_r.ifs;
          // same oscillator behind both settings: it is running already
          if (tgt_src == cks_pkg::SRC_INT && s_r.cur_src == cks_pkg::SRC_INT
              && is_lf(s_r.ifs) == is_lf(s_r.cur_ifs))
            s_nxt.sw = cks_pkg::SW_FALL;
          else
            s_nxt.sw = cks_pkg::SW_START;
        end
      end
      cks_pkg::SW_START: begin
        if (tgt_src != s_r.new_src)
          s_nxt.sw = cks_pkg::SW_IDLE;
        else if (tgt_ready)
          s_nxt.sw = cks_pkg::SW_FALL;
      end
      cks_pkg::SW_FALL: begin
        if (s_r.cur_d && !cur_lvl) begin
          s_nxt.sw = cks_pkg::SW_HOLD;
          if (s_r.new_src == cks_pkg::SRC_FUSED && xtal)
            s_nxt.timeout = 1'b1;
        end
      end
      cks_pkg::SW_HOLD: begin
        // crystal hand-over waits a falling edge, the rest a rising edge
        if ((s_r.new_src == cks_pkg::SRC_FUSED && xtal) ? (s_r.new_d && !new_lvl)
                                                         : (!s_r.new_d && new_lvl)) begin
          s_nxt.sw      = cks_pkg::SW_IDLE;
          s_nxt.cur_src = s_r.new_src;
          s_nxt.cur_ifs = s_r.new_ifs;
          if (s_r.new_src == cks_pkg::SRC_FUSED && !fused_int)
            s_nxt.timeout = 1'b1;
          else if (s_r.new_src == cks_pkg::SRC_INT)
            s_nxt.timeout = 1'b0;
        end
      end
    endcase
    if (sleep_req && xtal && !s_r.ost_done)
      s_nxt.timeout = 1'b0;

    // output low through the hold so no short pulse escapes
    s_nxt.clk_o = (s_nxt.sw == cks_pkg::SW_HOLD) ? 1'b0 : cur_lvl;

    // oscillator enables and status
    // the oscillator behind the live or the incoming internal clock stays on until the switch ends,
    // otherwise a frozen waveform never gives the edge that the sequencer waits for
    int_live = s_r.cur_src == cks_pkg::SRC_INT;
    int_next = s_r.sw != cks_pkg::SW_IDLE && s_r.new_src == cks_pkg::SRC_INT;
    hf_busy  = (int_live && !is_lf(s_r.cur_ifs)) || (int_next && !is_lf(s_r.new_ifs));
    lf_busy  = (int_live && is_lf(s_r.cur_ifs)) || (int_next && is_lf(s_r.new_ifs));
    s_nxt.hf_en = (!is_lf(s_r.ifs) && (fused_int || s_r.sel[1] || two_speed)) || hf_busy;
    s_nxt.lf_en = (is_lf(s_r.ifs) && (fused_int || s_r.sel[1] || two_speed)) || lf_busy
                  || power_up_timer_on || watchdog_timer_on || failsafe_monitor_on;
    s_nxt.hf_rdy  = s_r.hf_en && hf_osc_ready;
    s_nxt.hf_stb  = s_r.hf_en && hf_osc_ready && hf_osc_stable;
    s_nxt.lf_rdy  = s_r.lf_en && lf_osc_ready;
    s_nxt.sec_rdy = !s_r.sec_en || sec_osc_ready;

    // read data latched in setup so the access phase answers at once
    if (psel && !penable) begin
      s_nxt.rdata = '0;
      unique case (paddr)
        cks_pkg::ADDR_CTRL: begin
          s_nxt.rdata[cks_pkg::IFS_MSB:cks_pkg::IFS_LSB] = s_r.ifs;
          s_nxt.rdata[cks_pkg::SEL_MSB:cks_pkg::SEL_LSB] = s_r.sel;
        end
        cks_pkg::ADDR_STAT: begin
          s_nxt.rdata[cks_pkg::ST_SEC_RDY] = s_r.sec_rdy;
          s_nxt.rdata[cks_pkg::ST_TIMEOUT] = s_r.timeout;
          s_nxt.rdata[cks_pkg::ST_HF_RDY]  = s_r.hf_rdy;
          s_nxt.rdata[cks_pkg::ST_LF_RDY]  = s_r.lf_rdy;
          s_nxt.rdata[cks_pkg::ST_HF_STB]  = s_r.hf_stb;
        end
        cks_pkg::ADDR_CFG: s_nxt.rdata[cks_pkg::CFG_SEC_EN] = s_r.sec_en;
        default: s_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r         <= '0;
      s_r.ifs     <= cks_pkg::IFS_RESET;
      s_r.sel     <= cks_pkg::SEL_RESET;
      s_r.cur_src <= cks_pkg::SRC_INT;
      s_r.cur_ifs <= cks_pkg::IFS_RESET;
      s_r.new_src <= cks_pkg::SRC_INT;
      s_r.new_ifs <= cks_pkg::IFS_RESET;
      s_r.sw      <= cks_pkg::SW_IDLE;
      s_r.sec_rdy <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  assign prdata               = s_r.rdata;
  assign pready               = apb_acc;
  assign pslverr              = apb_acc && !mapped;
  assign hf_osc_en            = s_r.hf_en;
  assign lf_osc_en            = s_r.lf_en;
  assign sec_osc_en           = s_r.sec_en;
  assign sys_clk_out          = s_r.clk_o;
  assign sys_clk_src          = s_r.cur_src;
  assign primary_pin_gpio     = fused_int;
  assign secondary_pin_clkout = fused_int && !clk_out_enable_fuse_n;

  // ***********************************************
  // assertions
  // ***********************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_fall_to_hold;
    s_r.sw == cks_pkg::SW_FALL ##1 s_r.sw == cks_pkg::SW_HOLD;
  endsequence
  sequence s_hold_to_idle;
    s_r.sw == cks_pkg::SW_HOLD ##1 s_r.sw == cks_pkg::SW_IDLE;
  endsequence

  AST_IFS_WRITE: assert property (apb_wr && paddr == cks_pkg::ADDR_CTRL |=>
    s_r.ifs == $past(pwdata[cks_pkg::IFS_MSB:cks_pkg::IFS_LSB])) else $error("freq select not stored");
  AST_SEL_ONLY_SW: assert property (!(apb_wr && paddr == cks_pkg::ADDR_CTRL) |=>
    $stable(s_r.sel)) else $error("clock select changed without a write");
  AST_HOLD_LOW: assert property (s_fall_to_hold |-> !sys_clk_out)
    else $error("clock not held low in hold");
  AST_COMMIT: assert property (s_hold_to_idle |-> s_r.cur_src == $past(s_r.new_src)
    && s_r.cur_ifs == $past(s_r.new_ifs)) else $error("switch did not commit target");
  AST_INT_FLAG: assert property (s_r.sw == cks_pkg::SW_IDLE && s_r.cur_src == cks_pkg::SRC_INT
    && $past(s_r.sw) == cks_pkg::SW_HOLD |-> !s_r.timeout) else $error("timeout flag set on internal");
  AST_SLEEP_ABORT: assert property (sleep_req && is_xtal(fused_osc_mode) && !s_r.ost_done
    |=> !s_r.ost_done && !s_r.timeout) else $error("sleep did not abort start-up");
  AST_OST_DONE: assert property ($rose(s_r.ost_done) |-> $past(s_r.ost_cnt) == OST_LAST)
    else $error("start-up timer expired at wrong count");
  AST_LF_TIMERS: assert property (watchdog_timer_on ##1 watchdog_timer_on |-> lf_osc_en)
    else $error("lf not enabled for watchdog");
  AST_HF_EN: assert property (s_r.sel[1] && !is_lf(s_r.ifs) ##1 $stable(s_r.ifs) && $stable(s_r.sel)
    |-> hf_osc_en) else $error("hf not enabled for internal hf select");
  AST_SEC_ENABLE: assert property (!sec_osc_en |-> s_r.sec_rdy || $past(sec_osc_en))
    else $error("secondary ready flag wrong while disabled");
  AST_RESET_SEL: assert property ($fell(rst) |-> s_r.sel == cks_pkg::SEL_RESET)
    else $error("clock select not cleared by reset");

endmodule : cks_clock_select

// ==== sim/cks_osc_model.sv ====
// oscillator sources and their status lines as seen by the clock select block
// assumes one block clock; waveforms are scaled far below real rates
`timescale 1ns/1ns
module cks_osc_model (
  input  wire logic clk, rst,           // block clock, reset
  input  wire logic hf_en, lf_en, sec_en, // oscillator enables
  output logic      ext_clk, sec_clk,   // crystal waveforms
  output logic      lf_clk, hf_clk,     // internal waveforms
  output logic      sec_rdy, lf_rdy,    // ready levels
  output logic      hf_rdy, hf_stb      // hf ready, stable
);
  localparam int HP[4] = '{4, 5, 7, 3};
  int         cnt[4];
  int         sec_age;
  logic [3:0] w;
  logic [3:0] run;
  // a disabled oscillator stands still instead of running free
  assign run = {hf_en, lf_en, sec_en, 1'b1};
  assign {hf_clk, lf_clk, sec_clk, ext_clk} = w;
  // the secondary crystal is slow to start, so ready trails enable
  assign sec_rdy = sec_en && sec_age >= 20;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w <= 4'h0;
      cnt <= '{0, 0, 0, 0};
      sec_age <= 0;
      {lf_rdy, hf_rdy, hf_stb} <= 3'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (run[i]) begin
          cnt[i] <= (cnt[i] == HP[i] - 1) ? 0 : cnt[i] + 1;
          if (cnt[i] == HP[i] - 1) w[i] <= ~w[i];
        end
      end
      sec_age <= !sec_en ? 0 : (sec_age < 20 ? sec_age + 1 : sec_age);
      lf_rdy <= lf_en;
      hf_rdy <= hf_en;
      hf_stb <= hf_rdy & hf_en;
    end
  end
endmodule : cks_osc_model

// ==== sim/tb_top.sv ====
// self-checking bench for the system clock select block
// assumes the oscillator model drives all oscillator waveform and status inputs
`timescale 1ns/1ns
module tb_top;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, fuse2, ckout_n;
  logic pwt_done, pwt_on, wdt_on, fsm_on, sleep, er;
  logic hfe, lfe, sece, eck, sck, lck, hck, srdy, lrdy, hrdy, hstb, sclk, pgp, pco;
  logic [7:0] paddr;
  logic [2:0] fused;
  logic [1:0] src;
  logic [31:0] pwdata, prdata, rd, d;
  int n_mismatch, total_checks, cyc, model_ctrl, per_n;
  localparam int HF_PERIOD = 6; // hf model toggles every 3 clocks
  cks_clock_select #(.OST_COUNT(8)) dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fused_osc_mode(fused), .two_speed_enable_fuse(fuse2),
    .clk_out_enable_fuse_n(ckout_n), .power_up_timer_done(pwt_done), .power_up_timer_on(pwt_on),
    .watchdog_timer_on(wdt_on), .failsafe_monitor_on(fsm_on), .sleep_req(sleep),
    .ext_osc_clk(eck), .sec_osc_clk(sck), .sec_osc_ready(srdy), .lf_osc_clk(lck),
    .lf_osc_ready(lrdy), .hf_osc_clk(hck), .hf_osc_ready(hrdy), .hf_osc_stable(hstb),
    .hf_osc_en(hfe), .lf_osc_en(lfe), .sec_osc_en(sece), .sys_clk_out(sclk),
    .sys_clk_src(src), .primary_pin_gpio(pgp), .secondary_pin_clkout(pco));
  cks_osc_model osc_u (.clk(clk), .rst(rst), .hf_en(hfe), .lf_en(lfe), .sec_en(sece),
    .ext_clk(eck), .sec_clk(sck), .lf_clk(lck), .hf_clk(hck), .sec_rdy(srdy),
    .lf_rdy(lrdy), .hf_rdy(hrdy), .hf_stb(hstb));
  always #50 clk = ~clk;
  // ***********************************************
  // helpers
  // ***********************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= v; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_src(input logic [1:0] v);
    for (int i = 0; i < 2000 && src !== v; i++) @(posedge clk);
  endtask : wait_src
  // clocks from one rising edge of the system clock to the next, once a switch has settled
  task sys_period(output int n);
    repeat (30) @(posedge clk);
    for (int i = 0; i < 400 && sclk !== 1'b0; i++) @(posedge clk);
    for (int i = 0; i < 400 && sclk !== 1'b1; i++) @(posedge clk);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sclk !== 1'b0 && n < 400);
    do begin
      @(posedge clk);
      n++;
    end while (sclk !== 1'b1 && n < 800);
  endtask : sys_period
  // polls a status bit; a bounded count keeps a dead oscillator from hanging the run
  task poll(input int b);
    for (int i = 0; i < 60; i++) begin
      apb(1'b0, cks_pkg::ADDR_STAT, 32'h0);
      if (rd[b] === 1'b1) break;
    end
  endtask : poll
  task do_reset;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    model_ctrl = int'(cks_pkg::IFS_RESET) << cks_pkg::IFS_LSB;
  endtask : do_reset
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ***********************************************
  // tests
  // ***********************************************
  initial begin
    clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; fused = 3'h0;
    fuse2 = 1; ckout_n = 1; pwt_done = 1; pwt_on = 0; wdt_on = 0; fsm_on = 0; sleep = 0;
    void'($urandom(32'h8276));
    do_reset();
    apb(1'b0, cks_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl reset", rd, model_ctrl);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped err", er, 1);
    chk("src while counting", src, 2);
    wait_src(2'h0);
    chk("src after startup", src, 0);
    apb(1'b0, cks_pkg::ADDR_STAT, 32'h0);
    chk("timeout set", rd[5], 1);
    apb(1'b0, cks_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl kept", rd, model_ctrl);
    $display("test startup done");
    d = ($urandom() & 32'hFFFF_FF80) | 32'h7A;
    model_ctrl = d & 32'h7B;
    apb(1'b1, cks_pkg::ADDR_CTRL, d);
    wait_src(2'h2);
    chk("src internal", src, 2);
    chk("hf enable", hfe, 1);
    apb(1'b0, cks_pkg::ADDR_STAT, 32'h0);
    chk("hf ready", rd[4], 1);
    chk("hf stable", rd[0], 1);
    chk("timeout clear", rd[5], 0);
    apb(1'b0, cks_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl readback", rd, model_ctrl);
    sys_period(per_n);
    chk("full rate", per_n, HF_PERIOD);
    apb(1'b1, cks_pkg::ADDR_CTRL, 32'h72);
    sys_period(per_n);
    chk("half rate", per_n, 2 * HF_PERIOD);
    apb(1'b1, cks_pkg::ADDR_CTRL, 32'h02);
    poll(cks_pkg::ST_LF_RDY);
    chk("lf ready", rd[1], 1);
    chk("lf enable", lfe, 1);
    $display("test internal done");
    apb(1'b1, cks_pkg::ADDR_CFG, 32'h1);
    @(posedge clk);
    chk("sec enable", sece, 1);
    poll(cks_pkg::ST_SEC_RDY);
    chk("sec ready", rd[cks_pkg::ST_SEC_RDY], 1);
    apb(1'b1, cks_pkg::ADDR_CTRL, 32'h01);
    wait_src(2'h1);
    chk("src secondary", src, 1);
    $display("test secondary done");
    do_reset();
    // the start-up timer is part way through when sleep cuts it short
    repeat (20) @(posedge clk);
    sleep <= 1'b1;
    wdt_on <= 1'b1;
    repeat (200) @(posedge clk);
    apb(1'b0, cks_pkg::ADDR_STAT, 32'h0);
    chk("timeout after sleep", rd[5], 0);
    chk("src asleep", src, 2);
    chk("lf for watchdog", lfe, 1);
    fused <= cks_pkg::FOSC_INTERNAL;
    ckout_n <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    chk("pin gpio", pgp, 1);
    chk("pin clkout", pco, 1);
    $display("test sleep done");
    end_of_test();
  end
endmodule : tb_top
